// >>> hdl/peer_consts.svh
// peer_consts.svh: offsets, field positions, reset values and codes of the peer event block
// assumes: included by the package by bare name; the design modules use its macros without including it
`ifndef PEER_CONSTS_SVH
`define PEER_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_IN_GROUP  8'h08
`define OFS_OUT_GROUP 8'h0C
`define OFS_PAGE_CFG  8'h10
`define OFS_OUT_STATE 8'h14
`define OFS_OUT_KIND  8'h18
`define OFS_VALUE     8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_LINK_UP_BIT  0
`define CTRL_CFG_DONE_BIT 1
`define CTRL_SWIPE_BIT    2
`define STATUS_PEER_BIT   0
`define STATUS_DEFLT_BIT  1

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define GROUP_OFF     8'h00
`define GROUP_DEFAULT 8'h01
`define EVT_CODE_ON   2'h1
`define EVT_CODE_OFF  2'h2
`define EVT_CODE_TGL  2'h3

`endif

// >>> hdl/peer_pkg.sv
// peer_pkg: types of the peer event block
// assumes: peer_consts.svh on the include path
package peer_pkg;
  `include "peer_consts.svh"

  typedef enum logic [1:0] {
    evt_none,
    evt_asserted,
    evt_released,
    evt_toggle
  } peer_evt_e;

  typedef enum logic {
    kind_switch,
    kind_blind
  } out_kind_e;

  // one message on the shared peer bus
  typedef struct packed {
    logic       valid;
    logic [7:0] group;
    peer_evt_e  evt;
  } peer_msg_s;

  typedef logic [7:0] group_t;
endpackage

// >>> hdl/key_event_gen.sv
// key_event_gen: turns a key level into asserted, released and toggle events
// assumes: key level synchronous to clk and already debounced
`timescale 1ns/1ps
`default_nettype none
module key_event_gen
  import peer_pkg::*;
#(
  parameter int unsigned SHORT_MAX = 16
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // key level
  input  wire logic  key,
  // event out
  output peer_evt_e  evt,
  output var logic   evt_valid
);
  localparam int unsigned CW = $clog2(SHORT_MAX + 1);

  logic          key_q;
  logic [CW-1:0] held_q;
  logic          tgl_pend_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      key_q <= 1'b0;
    end else begin
      key_q <= key;
    end
  end

  // press time; saturates so a long hold never reads as short
  always_ff @(posedge clk) begin
    if (srst || (key && !key_q)) begin
      held_q <= '0;
    end else if (key && held_q != CW'(SHORT_MAX)) begin
      held_q <= held_q + CW'(1);
    end
  end

  // toggle goes out one cycle after the release so events never collide
  always_ff @(posedge clk) begin
    if (srst) begin
      tgl_pend_q <= 1'b0;
    end else begin
      tgl_pend_q <= !key && key_q && held_q != CW'(SHORT_MAX); // [R15]
    end
  end

  always_comb begin
    evt = evt_none;
    if (key && !key_q) begin
      evt = evt_asserted; // [R15]
    end else if (!key && key_q) begin
      evt = evt_released; // [R15]
    end else if (tgl_pend_q) begin
      evt = evt_toggle; // [R15]
    end
    evt_valid = (evt != evt_none);
  end
endmodule // key_event_gen
`default_nettype wire

// >>> hdl/blind_motor_obj.sv
// blind_motor_obj: up/down relay pair driven by peer events
// assumes: one event at most per cycle
`timescale 1ns/1ps
`default_nettype none
module blind_motor_obj
  import peer_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      srst,
  // event
  input  wire logic      evt_valid,
  input  wire peer_evt_e evt,
  // central unit control when peer mode is off
  input  wire logic      host_en,
  input  wire logic      host_up,
  input  wire logic      host_down,
  // relays
  output logic           relay_up,
  output logic           relay_down,
  output logic           last_dir_up
);
  logic up_q;
  logic dn_q;
  logic dir_up_q;
  logic relay_up_prev;
  logic relay_dn_prev;

  // relays run until an event stops them; the travel timeout is not applied here
  always_ff @(posedge clk) begin
    if (srst) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if (host_en) begin
      up_q <= host_up && !host_down; // [R20]
      dn_q <= host_down && !host_up; // [R20]
    end else if (evt_valid) begin
      case (evt)
        evt_asserted: begin
          if (!up_q && !dn_q) begin
            up_q <= dir_up_q; // [R16]
            dn_q <= !dir_up_q; // [R16]
          end
        end
        evt_released: begin
          up_q <= 1'b0; // [R17] [R19]
          dn_q <= 1'b0;
        end
        evt_toggle: begin
          if (up_q || dn_q) begin
            up_q <= 1'b0; // [R18]
            dn_q <= 1'b0;
          end else begin
            up_q <= dir_up_q; // [R18]
            dn_q <= !dir_up_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // remembered direction is set opposite to each run as it starts so the next start reverses
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_up_q <= 1'b1;
    end else if ((up_q && !relay_up_prev) || (dn_q && !relay_dn_prev)) begin
      dir_up_q <= dn_q; // [R20]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      relay_up_prev <= 1'b0;
      relay_dn_prev <= 1'b0;
    end else begin
      relay_up_prev <= up_q;
      relay_dn_prev <= dn_q;
    end
  end

  assign relay_up    = up_q;
  assign relay_down  = dn_q;
  assign last_dir_up = dir_up_q;
endmodule // blind_motor_obj
`default_nettype wire

// >>> hdl/peer_event_action_logic.sv
// peer_event_action_logic: peer input-to-output action logic of one module
// assumes: AHB-Lite single slave, single word transfers; keys synchronous to clk
//
// Functional notes
// R1 - group zero disables peer operation
// R2 - first bus join sets group one
// R3 - configuration delivery leaves default mode
// R4 - panel four group settings start at one
// R5 - group held per input and output
// R6 - link lost: input event messages same group
// R7 - output applies action of event kind
// R8 - page holds group; slots bind keys
// R9 - panel peer: sixteen keys, swipe paging
// R10 - page joins only in button mode
// R11 - event-to-action mapping fixed
// R12 - asserted event turns output on
// R13 - released event turns output off
// R14 - toggle event inverts output state
// R15 - press, release, short press make events
// R16 - blind asserted: relay by last direction
// R17 - blind released: energised relay off
// R18 - blind toggle: stop, else start
// R19 - no timeout on peer-driven relays
// R20 - record direction, never both relays
// R21 - link return: report real state, revert
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module peer_event_action_logic
  import peer_pkg::*;
#(
  parameter int unsigned N_IN      = 4,
  parameter int unsigned N_OUT     = 4,
  parameter int unsigned N_PAGE    = 4,
  parameter int unsigned N_SLOT    = 4,
  parameter int unsigned SHORT_MAX = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // local inputs and panel keys
  input  wire logic [N_IN-1:0]   in_key,
  input  wire logic              swipe_next,
  // shared peer bus
  input  wire peer_msg_s         msg_rx,
  output peer_msg_s              msg_tx,
  // outputs
  output logic [N_OUT-1:0]       out_on,
  output logic [N_OUT-1:0]       relay_up,
  output logic [N_OUT-1:0]       relay_down
);
  localparam int unsigned N_KEY = N_PAGE * N_SLOT;
  localparam int unsigned PW    = (N_PAGE > 1) ? $clog2(N_PAGE) : 1;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic                  link_up_q;
  logic                  cfg_done_q;
  logic                  default_q;
  logic [N_IN-1:0][7:0]  in_grp_q;
  logic [N_OUT-1:0][7:0] out_grp_q;
  logic [N_PAGE-1:0][7:0] page_grp_q;
  logic [N_PAGE-1:0]     page_btn_mode_q;
  logic [N_OUT-1:0]      out_kind_q;
  logic [N_OUT-1:0]      host_out_q;
  logic [N_OUT-1:0]      sw_q;
  logic [N_OUT-1:0]      value_q;
  logic [PW-1:0]         page_q;
  logic                  link_q;
  logic                  swipe_q;
  peer_msg_s             tx_q;

  // ----------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------
  logic       dp_wr_q;
  logic       dp_rd_q;
  logic [7:0] dp_addr_q;
  logic       ap_take;

  assign ap_take = hsel && hready && htrans[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hready) begin
      dp_wr_q   <= ap_take && hwrite;
      dp_rd_q   <= ap_take && !hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end

  // no wait states: every register answers in its data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  logic [5:0] page_idx;
  logic       wr_ctrl;
  assign page_idx = dp_addr_q[7:2] - 6'(`OFS_PAGE_CFG >> 2);
  assign wr_ctrl  = dp_wr_q && dp_addr_q == `OFS_CTRL;

  // ----------------------------------------
  // control and default mode
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      link_up_q  <= 1'b0;
      cfg_done_q <= 1'b0;
    end else if (wr_ctrl) begin
      link_up_q  <= hwdata[`CTRL_LINK_UP_BIT];
      cfg_done_q <= hwdata[`CTRL_CFG_DONE_BIT];
    end
  end

  // default mode until a configuration is delivered
  always_ff @(posedge clk) begin
    if (srst) begin
      default_q <= 1'b1; // [R2]
    end else if (wr_ctrl && hwdata[`CTRL_CFG_DONE_BIT]) begin
      default_q <= 1'b0; // [R3]
    end
  end

  // ----------------------------------------
  // group tables, one per object
  // ----------------------------------------
  // reset is the first bus join: groups start at one in default mode
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < N_IN; i++) in_grp_q[i] <= `GROUP_DEFAULT; // [R2] [R5]
      for (int i = 0; i < N_OUT; i++) out_grp_q[i] <= `GROUP_DEFAULT; // [R5]
      for (int i = 0; i < N_PAGE; i++) page_grp_q[i] <= `GROUP_DEFAULT; // [R4] [R8]
      page_btn_mode_q <= '1;
      out_kind_q      <= '0;
      host_out_q      <= '0;
    end else if (dp_wr_q) begin
      if (dp_addr_q == `OFS_IN_GROUP) begin
        for (int i = 0; i < N_IN && i < 4; i++) in_grp_q[i] <= hwdata[8*i +: 8]; // [R5]
      end else if (dp_addr_q == `OFS_OUT_GROUP) begin
        for (int i = 0; i < N_OUT && i < 4; i++) out_grp_q[i] <= hwdata[8*i +: 8]; // [R5]
      end else if (dp_addr_q >= `OFS_PAGE_CFG && dp_addr_q < `OFS_OUT_STATE) begin
        for (int i = 0; i < N_PAGE; i++) begin
          if (page_idx == 6'(i)) begin
            page_grp_q[i]      <= hwdata[7:0]; // [R8]
            page_btn_mode_q[i] <= hwdata[8]; // [R10]
          end
        end
      end else if (dp_addr_q == `OFS_OUT_KIND) begin
        out_kind_q <= hwdata[N_OUT-1:0];
      end else if (dp_addr_q == `OFS_OUT_STATE) begin
        host_out_q <= hwdata[N_OUT-1:0];
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_rd_q) begin
      if (dp_addr_q == `OFS_CTRL) begin
        hrdata[`CTRL_LINK_UP_BIT]  = link_up_q;
        hrdata[`CTRL_CFG_DONE_BIT] = cfg_done_q;
      end else if (dp_addr_q == `OFS_STATUS) begin
        hrdata[`STATUS_PEER_BIT]  = !link_up_q;
        hrdata[`STATUS_DEFLT_BIT] = default_q;
        hrdata[15:8]              = 8'(page_q);
      end else if (dp_addr_q == `OFS_IN_GROUP) begin
        for (int i = 0; i < N_IN && i < 4; i++) hrdata[8*i +: 8] = in_grp_q[i];
      end else if (dp_addr_q == `OFS_OUT_GROUP) begin
        for (int i = 0; i < N_OUT && i < 4; i++) hrdata[8*i +: 8] = out_grp_q[i];
      end else if (dp_addr_q == `OFS_OUT_KIND) begin
        hrdata[N_OUT-1:0] = out_kind_q;
      end else if (dp_addr_q == `OFS_VALUE) begin
        hrdata[N_OUT-1:0] = value_q;
      end else if (dp_addr_q >= `OFS_PAGE_CFG && dp_addr_q < `OFS_OUT_STATE) begin
        for (int i = 0; i < N_PAGE; i++) begin
          if (page_idx == 6'(i)) begin
            hrdata[7:0] = page_grp_q[i];
            hrdata[8]   = page_btn_mode_q[i];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // panel paging by swipe
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      page_q  <= '0;
      swipe_q <= 1'b0;
    end else begin
      swipe_q <= swipe_next;
      if (swipe_next && !swipe_q && !link_up_q) begin
        page_q <= (page_q == PW'(N_PAGE - 1)) ? '0 : page_q + PW'(1); // [R9]
      end
    end
  end

  // ----------------------------------------
  // event sources: local inputs; keys map to slots of the shown page
  // ----------------------------------------
  peer_evt_e [N_IN-1:0] kev;
  logic [N_IN-1:0]      kev_v;

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_key
      key_event_gen #(
        .SHORT_MAX (SHORT_MAX)
      ) u_key (
        .clk       (clk),
        .srst      (srst),
        .key       (in_key[gi]),
        .evt       (kev[gi]),
        .evt_valid (kev_v[gi])
      );
    end
  endgenerate

  peer_msg_s tx_next;

  // lowest-numbered event wins; others in the same cycle are dropped
  always_comb begin
    peer_msg_s m;
    m = '0;
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (kev_v[i]) begin
        m.valid = 1'b1;
        m.evt   = kev[i];
        // page object carries the group in button mode only
        if (i < N_SLOT && page_btn_mode_q[page_q]) begin
          m.group = page_grp_q[page_q]; // [R8] [R10]
        end else if (i < N_SLOT) begin
          m.group = `GROUP_OFF; // [R10]
        end else begin
          m.group = in_grp_q[i];
        end
      end
    end
    // central unit owns the outputs while the link is up
    if (link_up_q || m.group == `GROUP_OFF) begin
      m.valid = 1'b0; // [R1] [R6]
    end
    tx_next = m;
  end

  // ----------------------------------------
  // message transmit; registered so the bus sees one clean pulse
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_next; // [R6]
    end
  end
  assign msg_tx = tx_q;

  // ----------------------------------------
  // output objects; fixed table, no configuration reaches it
  // ----------------------------------------
  logic [N_OUT-1:0] hit;
  logic [N_OUT-1:0] up_w;
  logic [N_OUT-1:0] dn_w;

  genvar go;
  generate
    for (go = 0; go < N_OUT; go++) begin : g_out
      assign hit[go] = msg_rx.valid && !link_up_q && out_grp_q[go] != `GROUP_OFF
                       && out_grp_q[go] == msg_rx.group; // [R1] [R7]

      // host level wins while the link is up; peer hits act only when it is down
      always_ff @(posedge clk) begin
        if (srst) begin
          sw_q[go] <= 1'b0;
        end else if (link_up_q) begin
          sw_q[go] <= host_out_q[go]; // [R21]
        end else if (hit[go] && out_kind_q[go] == kind_switch) begin
          case (msg_rx.evt)
            evt_asserted: sw_q[go] <= 1'b1; // [R11] [R12]
            evt_released: sw_q[go] <= 1'b0; // [R13]
            evt_toggle:   sw_q[go] <= !sw_q[go]; // [R14]
            default:      sw_q[go] <= sw_q[go];
          endcase
        end
      end

      // host sets the up relay from its level and forces down off; down runs only on peer events
      blind_motor_obj u_blind (
        .clk         (clk),
        .srst        (srst),
        .evt_valid   (hit[go] && out_kind_q[go] == kind_blind),
        .evt         (msg_rx.evt),
        .host_en     (link_up_q),
        .host_up     (host_out_q[go] && out_kind_q[go] == kind_blind),
        .host_down   (1'b0),
        .relay_up    (up_w[go]),
        .relay_down  (dn_w[go]),
        .last_dir_up ()
      );
    end
  endgenerate

  // ----------------------------------------
  // reported value tracks real output state when the link returns
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      link_q  <= 1'b0;
      value_q <= '0;
    end else begin
      link_q <= link_up_q;
      if (link_up_q && !link_q) begin
        value_q <= sw_q | up_w | dn_w; // [R21]
      end else if (link_up_q) begin
        value_q <= sw_q | up_w | dn_w;
      end
    end
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  assign out_on     = sw_q;
  assign relay_up   = up_w;
  assign relay_down = dn_w;
endmodule // peer_event_action_logic
`default_nettype wire

// >>> bench/peer_event_action_logic_chk.sv
// peer_chk: port-level properties of the peer action block
// assumes: bound into peer_event_action_logic, one clock domain
`timescale 1ns/1ps
`default_nettype none
module peer_chk
  import peer_pkg::*;
#(
  parameter int unsigned N_IN  = 4,
  parameter int unsigned N_OUT = 4
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             srst,
  // bus
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // peer side
  input wire logic [N_IN-1:0]  in_key,
  input wire peer_msg_s        msg_rx,
  input wire peer_msg_s        msg_tx,
  input wire logic [N_OUT-1:0] out_on,
  input wire logic [N_OUT-1:0] relay_up,
  input wire logic [N_OUT-1:0] relay_down
);
  // ----------------------------------------
  // history helpers
  // ----------------------------------------
  logic [N_IN-1:0] k1_q, k2_q, k3_q;
  logic [3:0]      wr_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    k1_q <= in_key;
    k2_q <= k1_q;
    k3_q <= k2_q;
  end
  // host writes may move outputs while the link is up
  always_ff @(posedge clk) begin
    if (srst) wr_q <= 4'h0;
    else wr_q <= {wr_q[2:0], hwrite & htrans[1]};
  end
  sequence rx_evt(e);
    msg_rx.valid && msg_rx.evt == e;
  endsequence
  sequence key_edge;
    (k1_q != k2_q) || (k2_q != k3_q);
  endsequence
  ready_high_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (!hresp)
    else $error("slave answered with an error");
  relay_excl_a: assert property ((relay_up & relay_down) == '0)
    else $error("both relays on at once");
  reset_idle_a: assert property (disable iff (1'b0) srst |=>
      out_on == '0 && relay_up == '0 && relay_down == '0 && !msg_tx.valid)
    else $error("outputs not idle after reset");
  msg_src_a: assert property (msg_tx.valid |-> key_edge ##0 msg_tx.evt != evt_none)
    else $error("message without a key edge");
  asrt_on_a: assert property (rx_evt(evt_asserted) |=> (~out_on & $past(out_on)) == '0)
    else $error("asserted event turned an output off");
  rel_off_a: assert property (rx_evt(evt_released) |=>
      (out_on & ~$past(out_on)) == '0 && ((relay_up | relay_down) & ~$past(relay_up | relay_down)) == '0)
    else $error("released event turned something on");
  relay_hold_a: assert property (
      |($past(relay_up | relay_down) & ~(relay_up | relay_down))
      |-> $past(msg_rx.valid) || |wr_q || $past(srst))
    else $error("relay dropped without a cause");
endmodule // peer_chk
bind peer_event_action_logic peer_chk #(.N_IN(N_IN), .N_OUT(N_OUT)) u_peer_chk (
  .clk(clk), .srst(srst), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hresp(hresp), .in_key(in_key), .msg_rx(msg_rx), .msg_tx(msg_tx), .out_on(out_on),
  .relay_up(relay_up), .relay_down(relay_down));
`default_nettype wire

// >>> bench/peer_node_model.sv
// peer_node_model: far-side peer module on the shared message bus
// assumes: send is called from the bench, one message per call
`timescale 1ns/1ps
`default_nettype none
module peer_node_model
  import peer_pkg::*;
(
  // clock
  input  wire logic      clk,
  // message bus
  input  wire peer_msg_s msg_tx,
  output peer_msg_s      msg_rx
);
  // ----------------------------------------
  // sender and listener
  // ----------------------------------------
  peer_msg_s req_m;
  logic      req;
  peer_msg_s seen_q[$];
  initial begin
    req    = 1'b0;
    msg_rx = '0;
  end
  // idle bus keeps moving so stale fields never look valid
  always @(posedge clk) begin
    if (req) msg_rx <= req_m;
    else msg_rx <= '{1'b0, ~msg_rx.group, peer_evt_e'(msg_rx.evt + 2'h1)};
    if (msg_tx.valid) seen_q.push_back(msg_tx);
  end
  // one pulse carrying group and event kind; release ends peer travel
  task automatic send(input group_t g, input peer_evt_e e);
    @(negedge clk);
    req_m = '{1'b1, g, e};
    req   = 1'b1;
    @(negedge clk);
    req   = 1'b0;
  endtask
endmodule // peer_node_model
`default_nettype wire

// >>> bench/peer_event_action_logic_tb.sv
// peer_event_action_logic_tb: self-checking bench with a queue-based model
// assumes: peer_node_model on the message bus, ahb-lite master tasks here
`timescale 1ns/1ps
`default_nettype none
module peer_event_action_logic_tb;
  import peer_pkg::*;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic        clk, srst, hsel, hwrite, swipe_next, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [3:0]  in_key, out_on, relay_up, relay_down, kmask;
  peer_msg_s   msg_rx, msg_tx;
  int          num_errors, checks, cyc, link_m;
  int          grp_m[4], on_m[4], dir_m[4], up_m[4], dn_m[4];
  logic [7:0]  lfsr;
  logic [31:0] ra[5] = '{32'h0000_0004, 32'h0000_0008, 32'h0000_000C, 32'h0000_0010, 32'h0000_0040};
  logic [31:0] re[5] = '{32'h0000_0003, 32'h0101_0101, 32'h0101_0101, 32'h0000_0001, 32'h0000_0000};
  logic [31:0] rm[5] = '{32'h0000_FF03, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF, 32'hFFFF_FFFF};
  peer_evt_e   sseq[6] = '{evt_asserted, evt_toggle, evt_toggle, evt_released, evt_toggle, evt_released};
  peer_evt_e   bseq[5] = '{evt_released, evt_asserted, evt_toggle, evt_toggle, evt_toggle};
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  peer_event_action_logic u_peer_event_action_logic (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .in_key(in_key), .swipe_next(swipe_next),
    .msg_rx(msg_rx), .msg_tx(msg_tx), .out_on(out_on), .relay_up(relay_up),
    .relay_down(relay_down));
  peer_node_model u_peer_node_model (.clk(clk), .msg_tx(msg_tx), .msg_rx(msg_rx));
  task automatic test_done;
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // fixed event-to-action table, never configurable
  task automatic apply(input int g, input peer_evt_e e);
    for (int i = 0; i < 4; i++) begin
      if (link_m == 0 && g != 0 && grp_m[i] == g) begin
        if (!kmask[i]) on_m[i] = (e == evt_asserted) ? 1 : (e == evt_released) ? 0 : !on_m[i];
        else if (e == evt_released || (e == evt_toggle && (up_m[i] | dn_m[i]))) begin
          up_m[i] = 0;
          dn_m[i] = 0;
        end else if ((up_m[i] | dn_m[i]) == 0) begin
          up_m[i]  = dir_m[i];
          dn_m[i]  = !dir_m[i];
          dir_m[i] = !dir_m[i];
        end
      end
    end
  endtask
  task automatic cmp_out;
    logic [3:0] on, up, dn;
    for (int i = 0; i < 4; i++) begin
      on[i] = on_m[i][0];
      up[i] = up_m[i][0];
      dn[i] = dn_m[i][0];
    end
    chk("out_on", 32'(out_on & ~kmask), 32'(on & ~kmask));
    chk("relay_up", 32'(relay_up), 32'(up));
    chk("relay_down", 32'(relay_down), 32'(dn));
  endtask
  task automatic rx(input int g, input peer_evt_e e);
    u_peer_node_model.send(group_t'(g), e);
    apply(g, e);
    @(negedge clk);
    cmp_out();
  endtask
  task automatic key(input int n, input int hold);
    @(posedge clk);
    in_key[n] <= 1'b1;
    repeat (hold) @(posedge clk);
    in_key[n] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic exp_tx(input int g, input peer_evt_e e);
    peer_msg_s m;
    m = '0;
    if (u_peer_node_model.seen_q.size() > 0) m = u_peer_node_model.seen_q.pop_front();
    chk("msg_tx", 32'(m), {21'h0, 1'b1, 8'(g), e});
  endtask
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    int          g;
    {srst, hsel, hwrite, swipe_next} = 4'h8;
    {haddr, hwdata, htrans, in_key} = '0;
    {num_errors, checks, cyc, link_m} = '0;
    lfsr = 8'h21;
    kmask = 4'h0;
    foreach (grp_m[i]) {grp_m[i], on_m[i], dir_m[i], up_m[i], dn_m[i]} = {32'd1, 32'd0, 32'd1, 64'd0};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, r);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0000_0000, r);
      chk("reg", r & rm[i], re[i]);
    end
    key(0, 30);
    exp_tx(1, evt_asserted);
    exp_tx(1, evt_released);
    key(1, 4);
    exp_tx(1, evt_asserted);
    exp_tx(1, evt_released);
    exp_tx(1, evt_toggle);
    bus(1'b1, 32'h0000_0010, 32'h0000_0001, r);
    key(3, 4);
    chk("page_off", u_peer_node_model.seen_q.size(), 32'h0000_0000);
    bus(1'b1, 32'h0000_0010, 32'h0000_0101, r);
    @(posedge clk);
    swipe_next <= 1'b1;
    @(posedge clk);
    swipe_next <= 1'b0;
    bus(1'b0, 32'h0000_0004, 32'h0000_0000, r);
    chk("page", r & 32'h0000_FF00, 32'h0000_0100);
    foreach (sseq[i]) rx(1, sseq[i]);
    lfsr = lfsr_next(lfsr);
    g = 2 + int'(lfsr) % 250;
    bus(1'b1, 32'h0000_000C, {8'h00, 8'(g), 8'h01, 8'h01}, r);
    grp_m = '{1, 1, g, 0};
    rx(g, evt_asserted);
    rx(1, evt_toggle);
    rx(0, evt_asserted);
    bus(1'b1, 32'h0000_000C, 32'h0101_0101, r);
    grp_m = '{1, 1, 1, 1};
    rx(1, evt_released);
    bus(1'b1, 32'h0000_0018, 32'h0000_0001, r);
    kmask = 4'h1;
    rx(1, evt_asserted);
    repeat (200) @(posedge clk);
    cmp_out();
    foreach (bseq[i]) rx(1, bseq[i]);
    bus(1'b1, 32'h0000_0018, 32'h0000_0000, r);
    kmask = 4'h0;
    bus(1'b1, 32'h0000_0014, 32'h0000_000A, r);
    bus(1'b1, 32'h0000_0000, 32'h0000_0001, r);
    link_m = 1;
    foreach (on_m[i]) on_m[i] = (10 >> i) & 1;
    rx(1, evt_asserted);
    key(2, 4);
    chk("tx_count", u_peer_node_model.seen_q.size(), 32'h0000_0000);
    bus(1'b0, 32'h0000_001C, 32'h0000_0000, r);
    chk("value", r, 32'h0000_000A);
    bus(1'b1, 32'h0000_0000, 32'h0000_0003, r);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000, r);
    chk("status", r & 32'h0000_0003, 32'h0000_0000);
    test_done();
  end
endmodule // peer_event_action_logic_tb
`default_nettype wire
